// [logic/ddc_pkg.sv]
// Constants and the state record of the dual converter input control.
// Assumes one 25 MHz clock and a zero-wait AHB-Lite master in front of it.
package ddc_pkg;

   // Field positions inside the captured configuration word.
   localparam int PD_BIT = 7;
   localparam int EN_BIT = 6;
   localparam int IL_BIT = 5;
   localparam int REF_BIT = 4;
   localparam int GAIN_MSB = 3;

   // Configuration word after reset: no power-down, converter disabled.
   localparam logic [7:0] CFG_RESET = 8'h00;

   // Byte offsets of the software registers.
   localparam logic [11:0] OFF_CONFIG = 12'h000;
   localparam logic [11:0] OFF_STATUS = 12'h004;
   localparam logic [11:0] OFF_SAMPLES = 12'h008;
   localparam logic [11:0] OFF_EDGES = 12'h00c;

   // Positions of the synchronised control pins in one vector.
   localparam int CTL_STROBE = 0;
   localparam int CTL_DSEL = 1;
   localparam int CTL_DPOS = 2;
   localparam int CTL_DNEG = 3;
   localparam int CTL_CLKIN = 4;

   // Value of the rising edge counter after reset.
   localparam logic [15:0] EDGES_RESET = 16'h0000;

   // Whole state of the block, registered in one process.
   typedef struct packed {
      logic [7:0] pa_m;
      logic [7:0] pa_s;
      logic [7:0] pb_m;
      logic [7:0] pb_s;
      logic [4:0] ctl_m;
      logic [4:0] ctl_s;
      logic strobe_d;
      logic conv_d;
      logic [7:0] cfg;
      logic standby;
      logic ref_en;
      logic [7:0] hold_a;
      logic [7:0] hold_b;
      logic [7:0] dac_a;
      logic [7:0] dac_b;
      logic clk_o;
      logic clk_oe;
      logic [15:0] edges;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
   } ddc_state_t;

endpackage

// [logic/ddc_top.sv]
// Input side of a dual 8-bit converter: sample ports, config word, clocks.
// Assumes all pins are asynchronous to ref_clk_in and slow beside it.
// Overview of operation
// - Config word is captured when the write strobe returns high.
// - Port A bit 7 is sample MSB, and power-down in a config write.
// - Port A bit 6 is sample bit 6, and converter enable in config.
// - Port A bit 5 is sample bit 5, and interleave enable in config.
// - Port A bit 4 selects reference: zero internal on, one internal off.
// - Port A bits 3..0 form the channel A gain trim, bit 3 MSB.
// - Channel A takes an 8-bit sample on port A, bit 7 MSB.
// - Channel B takes an 8-bit sample on port B, bit 7 MSB.
// - Clock select low takes the conversion clock from the pair.
// - Clock select high ignores the pair and uses the single pin.
// - In differential mode the single pin is driven as clock copy.
// - Samples register on a rising edge; output updates on the next.
// - Interleaved: B taken from port A on falls, A on rises.
// - Power-down bit forces power-down; both bits zero mean standby.
// - Config capture does not depend on the conversion clock.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
module ddc_top (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic [7:0] port_a_in,
   input wire logic [7:0] port_b_in,
   input wire logic config_write_strobe_n_in,
   input wire logic diff_clock_select_n_in,
   input wire logic diff_clock_pos_in,
   input wire logic diff_clock_neg_in,
   input wire logic clock_pin_in,
   output logic clock_pin_out,
   output logic clock_pin_oe_out,
   output logic [7:0] dac_a_out,
   output logic [7:0] dac_b_out,
   output logic power_down_out,
   output logic standby_out,
   output logic interleave_out,
   output logic internal_ref_en_out,
   output logic [3:0] gain_trim_out,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out
);

   ddc_pkg::ddc_state_t st_r;
   ddc_pkg::ddc_state_t st_nxt;
   logic conv_lvl;
   logic rise_ev;
   logic fall_ev;
   logic cfg_ev;
   logic sw_cfg_wr;
   logic addr_rd;
   logic addr_wr;
   logic edge_clr;

   // Read multiplexer over the software registers; unmapped reads zero.
   function automatic logic [31:0] read_mux(input logic [11:0] off,
                                             input ddc_pkg::ddc_state_t s);
      logic [31:0] v;
      v = 32'h0000_0000;
      case (off)
         ddc_pkg::OFF_CONFIG: v = {24'h00_0000, s.cfg};
         ddc_pkg::OFF_STATUS: v = {26'h000_0000, s.clk_oe, s.ctl_s[1],
                                   s.conv_d, s.standby, s.cfg[7], s.cfg[6]};
         ddc_pkg::OFF_SAMPLES: v = {16'h0000, s.dac_b, s.dac_a};
         ddc_pkg::OFF_EDGES: v = {16'h0000, s.edges};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Conversion clock source follows the synchronised select pin.
   assign conv_lvl = st_r.ctl_s[ddc_pkg::CTL_DSEL] ?
                     st_r.ctl_s[ddc_pkg::CTL_CLKIN] :
                     (st_r.ctl_s[ddc_pkg::CTL_DPOS] &
                      ~st_r.ctl_s[ddc_pkg::CTL_DNEG]);

   // Edge events of the conversion clock and of the write strobe.
   assign rise_ev = conv_lvl & ~st_r.conv_d;
   assign fall_ev = ~conv_lvl & st_r.conv_d;
   assign cfg_ev = st_r.ctl_s[ddc_pkg::CTL_STROBE] & ~st_r.strobe_d;

   // Bus address phase qualification and a pending config write.
   assign addr_rd = hsel_in & hready_in & htrans_in[1] & ~hwrite_in;
   assign addr_wr = hsel_in & hready_in & htrans_in[1] & hwrite_in;
   assign sw_cfg_wr = st_r.wr_pend & (st_r.wr_addr == ddc_pkg::OFF_CONFIG);
   assign edge_clr = st_r.wr_pend & (st_r.wr_addr == ddc_pkg::OFF_EDGES);

   // Next state of every register in the block.
   always_comb begin
      st_nxt = st_r;
      // Two flip-flops on every pin before any logic sees it.
      st_nxt.pa_m = port_a_in;
      st_nxt.pa_s = st_r.pa_m;
      st_nxt.pb_m = port_b_in;
      st_nxt.pb_s = st_r.pb_m;
      st_nxt.ctl_m = {clock_pin_in, diff_clock_neg_in, diff_clock_pos_in,
                      diff_clock_select_n_in, config_write_strobe_n_in};
      st_nxt.ctl_s = st_r.ctl_m;
      st_nxt.strobe_d = st_r.ctl_s[ddc_pkg::CTL_STROBE];
      st_nxt.conv_d = conv_lvl;
      // The pin strobe wins over a software write in the same cycle.
      if (cfg_ev) begin
         st_nxt.cfg = st_r.pa_s;
      end else if (sw_cfg_wr) begin
         st_nxt.cfg = hwdata_in[7:0];
      end
      // Standby only while neither power-down nor enable is set.
      st_nxt.standby = ~st_nxt.cfg[ddc_pkg::PD_BIT] &
                       ~st_nxt.cfg[ddc_pkg::EN_BIT];
      // The reference enable is registered so the output leaves a flop.
      st_nxt.ref_en = ~st_nxt.cfg[ddc_pkg::REF_BIT];
      // Rising edge: latch inputs, and move the last latch to the core.
      if (rise_ev) begin
         st_nxt.hold_a = st_r.pa_s;
         if (!st_r.cfg[ddc_pkg::IL_BIT]) begin
            st_nxt.hold_b = st_r.pb_s;
         end
         st_nxt.dac_a = st_r.hold_a;
         st_nxt.dac_b = st_r.hold_b;
      end
      // Falling edge in interleaved mode takes channel B from port A.
      if (fall_ev && st_r.cfg[ddc_pkg::IL_BIT]) begin
         st_nxt.hold_b = st_r.pa_s;
      end
      // The single pin mirrors the pair only in differential mode.
      st_nxt.clk_oe = ~st_r.ctl_s[ddc_pkg::CTL_DSEL];
      st_nxt.clk_o = st_r.ctl_s[ddc_pkg::CTL_DSEL] ? 1'b0 : conv_lvl;
      // Edge counter: a software clear loses to a coinciding edge.
      if (edge_clr) begin
         st_nxt.edges = {15'h0000, rise_ev};
      end else if (rise_ev) begin
         st_nxt.edges = st_r.edges + 16'h0001;
      end
      // Bus data phase bookkeeping; read data comes ready for the phase.
      st_nxt.wr_pend = addr_wr;
      st_nxt.wr_addr = addr_wr ? haddr_in[11:0] : 12'h000;
      st_nxt.rdata = addr_rd ? read_mux(haddr_in[11:0], st_r) :
                     32'h0000_0000;
      if (reset_in) begin
         st_nxt = '0;
         st_nxt.cfg = ddc_pkg::CFG_RESET;
         st_nxt.standby = 1'b1;
         st_nxt.edges = ddc_pkg::EDGES_RESET;
         st_nxt.ref_en = ~ddc_pkg::CFG_RESET[ddc_pkg::REF_BIT];
         // The strobe idles high, so its copies start high: no false edge.
         st_nxt.ctl_m[ddc_pkg::CTL_STROBE] = 1'b1;
         st_nxt.ctl_s[ddc_pkg::CTL_STROBE] = 1'b1;
         st_nxt.strobe_d = 1'b1;
      end
   end

   // The one state register.
   always_ff @(posedge ref_clk_in) begin
      st_r <= st_nxt;
   end

   // Core controls from the held configuration word and its flops; samples, clock pin and read data from their registers.
   assign power_down_out = st_r.cfg[ddc_pkg::PD_BIT];
   assign interleave_out = st_r.cfg[ddc_pkg::IL_BIT];
   assign internal_ref_en_out = st_r.ref_en;
   assign gain_trim_out = st_r.cfg[ddc_pkg::GAIN_MSB:0];
   assign standby_out = st_r.standby;
   assign dac_a_out = st_r.dac_a;
   assign dac_b_out = st_r.dac_b;
   assign clock_pin_out = st_r.clk_o;
   assign clock_pin_oe_out = st_r.clk_oe;
   assign hrdata_out = st_r.rdata;
   // Zero-wait slave that always answers OKAY.
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (reset_in);

   // Strobe release loads the whole word from port A.
   property p_cfg_capture;
      cfg_ev |=> (st_r.cfg == $past(st_r.pa_s));
   endproperty
   a_cfg_capture: assert property (p_cfg_capture)
      else $error("Config word not captured on strobe release.");

   // Power-down bit follows port A bit 7 of the write.
   property p_pd_bit;
      cfg_ev |=> (power_down_out == $past(st_r.pa_s[7]));
   endproperty
   a_pd_bit: assert property (p_pd_bit)
      else $error("Power-down bit not taken from port A bit 7.");

   // Standby exactly when enable and power-down are both zero.
   property p_standby;
      standby_out == (~power_down_out & ~st_r.cfg[6]);
   endproperty
   a_standby: assert property (p_standby)
      else $error("Standby does not match enable and power-down.");

   // Interleave, reference and trim follow the written word.
   property p_fields;
      cfg_ev |=> (interleave_out == $past(st_r.pa_s[5])) &&
                 (internal_ref_en_out == !$past(st_r.pa_s[4])) &&
                 (gain_trim_out == $past(st_r.pa_s[3:0]));
   endproperty
   a_fields: assert property (p_fields)
      else $error("Mode, reference or trim field wrong after write.");

   // A sample latched at one rise reaches the core at the next rise.
   property p_pipe_a;
      rise_ev |=> (dac_a_out == $past(st_r.hold_a)) &&
                  (dac_b_out == $past(st_r.hold_b));
   endproperty
   a_pipe_a: assert property (p_pipe_a)
      else $error("Channel A output not updated on next rising edge.");

   // Non-interleaved channel B latches port B on a rise.
   property p_port_b;
      (rise_ev && !interleave_out) |=> (st_r.hold_b == $past(st_r.pb_s));
   endproperty
   a_port_b: assert property (p_port_b)
      else $error("Channel B sample not taken from port B.");

   // Interleaved channel B comes from port A on a fall.
   property p_interleave;
      (fall_ev && interleave_out) |=> (st_r.hold_b == $past(st_r.pa_s));
   endproperty
   a_interleave: assert property (p_interleave)
      else $error("Interleaved channel B not taken on falling edge.");

   // Differential mode drives the pin with the pair's clock.
   property p_mirror;
      !st_r.ctl_s[1] |=> clock_pin_oe_out &&
                         (clock_pin_out == $past(conv_lvl));
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("Clock pin does not mirror differential clock.");

   // Single-ended mode releases the pin and clocks from it.
   property p_single;
      st_r.ctl_s[1] |-> (conv_lvl == st_r.ctl_s[4]) ##1 !clock_pin_oe_out;
   endproperty
   a_single: assert property (p_single)
      else $error("Single-ended mode still drives clock pin.");

   // Without any write the configuration stays put.
   property p_hold;
      (!cfg_ev && !sw_cfg_wr) |=> $stable(st_r.cfg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("Configuration changed without a write.");

   // A rise latches port A as the channel A sample.
   property p_sample_a;
      rise_ev |=> (st_r.hold_a == $past(st_r.pa_s));
   endproperty
   a_sample_a: assert property (p_sample_a)
      else $error("Channel A sample not taken from port A.");

   // Between rises the core outputs stand still.
   property p_dac_steady;
      !rise_ev |=> $stable(dac_a_out) && $stable(dac_b_out);
   endproperty
   a_dac_steady: assert property (p_dac_steady)
      else $error("Core outputs changed without a rising edge.");

   // A bus write to the config register loads its low byte.
   property p_sw_cfg;
      (sw_cfg_wr && !cfg_ev) |=> (st_r.cfg == $past(hwdata_in[7:0]));
   endproperty
   a_sw_cfg: assert property (p_sw_cfg)
      else $error("Bus write did not load the configuration word.");

   // The reference enable flop always opposes the held reference bit.
   property p_ref_en;
      internal_ref_en_out == !st_r.cfg[ddc_pkg::REF_BIT];
   endproperty
   a_ref_en: assert property (p_ref_en)
      else $error("Internal reference enable disagrees with config.");

   // Every rise adds one to the edge counter unless it is cleared.
   property p_edge_count;
      (rise_ev && !edge_clr) |=>
         (st_r.edges == $past(st_r.edges) + 16'h0001);
   endproperty
   a_edge_count: assert property (p_edge_count)
      else $error("Edge counter did not count a rising edge.");

   // A clear meeting an edge leaves a count of one: the edge wins.
   property p_edge_clear;
      edge_clr |=> (st_r.edges == {15'h0000, $past(rise_ev)});
   endproperty
   a_edge_clear: assert property (p_edge_clear)
      else $error("Edge counter clear does not let the edge win.");

   // Read data stands only in the cycle after a read address phase.
   property p_read_idle;
      !addr_rd |=> (hrdata_out == 32'h0000_0000);
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("Read data shown outside a read data phase.");

   // Main scenarios.
   c_cfg_write: cover property (cfg_ev ##1 interleave_out);
   c_sw_cfg: cover property (sw_cfg_wr ##1 power_down_out);
   c_interleave_fall: cover property (fall_ev && interleave_out);
   c_cfg_with_clock: cover property (cfg_ev && rise_ev);
   c_mode_switch: cover property ($fell(st_r.ctl_s[1]));

endmodule

// [tb/ddc_src.sv]
// Behavioural sample source and configuration writer for the converter.
// Assumes the bench clock drives clk_in; every change lands after an edge.
module ddc_src (
   input wire logic clk_in,
   output logic [7:0] pa_out,
   output logic [7:0] pb_out,
   output logic stb_n_out,
   output logic dsel_n_out,
   output logic pos_out,
   output logic neg_out,
   output logic clk_pin_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle levels: strobe high, differential mode, clocks low.
   initial begin
      pa_out = 8'h00;
      pb_out = 8'h00;
      stb_n_out = 1'b1;
      dsel_n_out = 1'b0;
      pos_out = 1'b0;
      neg_out = 1'b0;
      clk_pin_out = 1'b0;
   end

   // Writes one word; each strobe level lasts four clocks, then settles.
   task automatic cfg(input logic [7:0] w);
      @(posedge clk_in);
      pa_out <= w;
      repeat (4) @(posedge clk_in);
      stb_n_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      stb_n_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      pa_out <= ~w;
   endtask

   // Picks the clock source and gives the select time to settle.
   task automatic mode(input logic dn);
      @(posedge clk_in);
      dsel_n_out <= dn;
      repeat (6) @(posedge clk_in);
   endtask

   // Sets data, then moves the active clock; the idle pair runs inverted.
   task automatic drive(input logic lvl, input logic [7:0] a, b);
      @(posedge clk_in);
      pa_out <= a;
      pb_out <= b;
      repeat (4) @(posedge clk_in);
      if (!dsel_n_out) begin
         pos_out <= lvl;
         neg_out <= ~lvl;
      end else begin
         clk_pin_out <= lvl;
         pos_out <= ~lvl;
         neg_out <= lvl;
      end
      repeat (4) @(posedge clk_in);
   endtask
endmodule

// [tb/dual_dac_input_control_tb_top.sv]
// Self-checking bench for the dual converter input control.
// Assumes the source model ddc_src and the design ddc_top.
module dual_dac_input_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwr = 1'b0;
   logic [1:0] htr = 2'b00;
   logic [31:0] hadr = 32'h0;
   logic [31:0] hwd = 32'h0;
   logic [31:0] hrd, rsmp, rv;
   logic hrdy, hresp, cko, coe, pd, sb, il, ren, stb, dsel, pos, neg, spin;
   logic [7:0] pa, pb, da, db;
   logic [3:0] gain;
   wire logic cpin;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;

   // The shared clock pin carries the design copy while it drives.
   assign cpin = coe ? cko : spin;

   ddc_top ddc_top_i (
      .ref_clk_in(clk), .reset_in(rst), .port_a_in(pa), .port_b_in(pb),
      .config_write_strobe_n_in(stb), .diff_clock_select_n_in(dsel),
      .diff_clock_pos_in(pos), .diff_clock_neg_in(neg),
      .clock_pin_in(cpin), .clock_pin_out(cko), .clock_pin_oe_out(coe),
      .dac_a_out(da), .dac_b_out(db), .power_down_out(pd),
      .standby_out(sb), .interleave_out(il), .internal_ref_en_out(ren),
      .gain_trim_out(gain), .hsel_in(hsel), .haddr_in(hadr),
      .htrans_in(htr), .hwrite_in(hwr), .hsize_in(3'b010),
      .hwdata_in(hwd), .hready_in(hrdy), .hrdata_out(hrd),
      .hreadyout_out(hrdy), .hresp_out(hresp));

   ddc_src ddc_src_i (.clk_in(clk), .pa_out(pa), .pb_out(pb),
      .stb_n_out(stb), .dsel_n_out(dsel), .pos_out(pos), .neg_out(neg),
      .clk_pin_out(spin));

   // Free-running 25 MHz clock.
   initial begin
      forever #20 clk = ~clk;
   end

   // Keeps the read data seen at each edge and cuts a hung run short.
   always @(posedge clk) begin
      rsmp <= hrd;
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         stop_test();
      end
   end

   // Prints the verdict and ends the run.
   task stop_test();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Compares one value and reports a difference.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One single word transfer; read data lands in rv.
   task automatic ahb(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      hadr <= a;
      htr <= 2'b10;
      hwr <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0;
      htr <= 2'b00;
      hwd <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      #1 rv = rsmp;
   endtask

   // Values held after reset.
   task automatic t_reset();
      chk(sb, 1'b1);
      chk(pd, 1'b0);
      chk(hresp, 1'b0);
      chk(hrdy, 1'b1);
   endtask

   // Every field decoded from a set of pin-written words.
   task automatic t_cfg();
      logic [7:0] w [6] = '{8'h80, 8'hc5, 8'h40, 8'h2a, 8'h15, 8'h00};
      foreach (w[i]) begin
         ddc_src_i.cfg(w[i]);
         chk(pd, w[i][7]);
         chk(sb, !w[i][7] && !w[i][6]);
         chk(il, w[i][5]);
         chk(ren, !w[i][4]);
         chk(gain, w[i][3:0]);
      end
   endtask

   // Differential clock: one-rise delay and the copied clock pin.
   task automatic t_diff();
      ddc_src_i.drive(1'b1, 8'ha5, 8'h3c);
      chk({coe, cko}, 2'b11);
      ddc_src_i.drive(1'b0, 8'hff, 8'hff);
      chk(cko, 1'b0);
      chk(da, 8'h00);
      ddc_src_i.drive(1'b1, 8'h11, 8'h22);
      ddc_src_i.drive(1'b0, 8'h00, 8'h00);
      chk({db, da}, 16'h3ca5);
   endtask

   // Single-ended clock: the pair runs inverted and must be ignored.
   task automatic t_single();
      ddc_src_i.mode(1'b1);
      chk(coe, 1'b0);
      ddc_src_i.drive(1'b0, 8'h00, 8'h00);
      ddc_src_i.drive(1'b1, 8'h5a, 8'hc3);
      ddc_src_i.drive(1'b0, 8'h81, 8'h18);
      ddc_src_i.drive(1'b1, 8'h00, 8'h00);
      ddc_src_i.drive(1'b0, 8'h00, 8'h00);
      chk({db, da}, 16'hc35a);
   endtask

   // Interleaved: port A carries B on the fall and A on the rise.
   task automatic t_il();
      ddc_src_i.mode(1'b0);
      ddc_src_i.cfg(8'h60);
      ddc_src_i.drive(1'b0, 8'h00, 8'h77);
      ddc_src_i.drive(1'b1, 8'h96, 8'h77);
      ddc_src_i.drive(1'b0, 8'h4d, 8'h77);
      ddc_src_i.drive(1'b1, 8'h00, 8'h77);
      chk({db, da}, 16'h4d96);
   endtask

   // Config word through the bus, read back, and an unmapped read.
   task automatic t_bus();
      ahb(1'b1, {20'h0, ddc_pkg::OFF_CONFIG}, 32'h95);
      ahb(1'b0, {20'h0, ddc_pkg::OFF_CONFIG}, 32'h0);
      chk(rv, 32'h95);
      chk({pd, ren, gain}, 6'h25);
      ahb(1'b0, {20'h0, ddc_pkg::OFF_STATUS}, 32'h0);
      chk(rv, 32'h2a);
      ahb(1'b0, {20'h0, ddc_pkg::OFF_SAMPLES}, 32'h0);
      chk(rv, 32'h4d96);
      ahb(1'b1, {20'h0, ddc_pkg::OFF_EDGES}, 32'h0);
      ahb(1'b0, {20'h0, ddc_pkg::OFF_EDGES}, 32'h0);
      chk(rv, 32'h0);
      ahb(1'b0, 32'h10, 32'h0);
      chk(rv, 32'h0);
   endtask

   // Main sequence.
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      t_reset();
      t_cfg();
      t_diff();
      t_single();
      t_il();
      @(posedge clk);
      t_bus();
      stop_test();
   end
endmodule
